// *** src/oeps_pkg.sv ***
package oeps_pkg;
  localparam int ACC_WIDTH = 24;
  localparam int ACC_COUNT = 4;
  localparam int PTR_WIDTH = 5;
  localparam int EE_ADDR_WIDTH = 11;
  localparam logic [10:0] EE_WINDOW_BASE = 11'h7D0;
  localparam logic [4:0] PTR_LAST_EE = 5'h0F;
  localparam int OR_REG_BYTES = 2;
  localparam int OR_IMM_BYTES = 5;
  localparam int STORE_BYTES = 4;
  localparam int SETPTR_BYTES = 1;
  localparam logic [16:0] OR_REG_CYCLES = 17'h00003;
  localparam logic [16:0] OR_IMM_CYCLES = 17'h00006;
  localparam logic [16:0] STORE_CYCLES = 17'h10000;
  localparam logic [16:0] SETPTR_CYCLES = 17'h00001;
  localparam logic [23:0] ACC_RESET = 24'h000000;
  localparam logic [4:0] PTR_RESET = 5'h00;

  typedef enum logic [3:0] {
    OEPS_OP_NONE = 4'h1,
    OEPS_OP_OR = 4'h2,
    OEPS_OP_STORE = 4'h4,
    OEPS_OP_SETPTR = 4'h8
  } oeps_op_type;

  typedef struct packed {
    oeps_op_type op;
    logic [1:0] dst;
    logic [1:0] src;
    logic use_imm;
    logic [23:0] imm;
    logic [4:0] ptr;
  } oeps_instr_type;

  typedef struct packed {
    logic carry;
    logic overflow;
    logic sign;
    logic zero;
  } oeps_flags_type;

  typedef struct packed {
    logic valid;
    logic [10:0] addr;
    logic [23:0] data;
  } oeps_ee_write_type;

  function automatic logic [16:0] oeps_cycles(input oeps_instr_type ins);
    logic [16:0] c;
    c = SETPTR_CYCLES;
    if (ins.op == OEPS_OP_OR)
      c = ins.use_imm ? OR_IMM_CYCLES : OR_REG_CYCLES;
    else if (ins.op == OEPS_OP_STORE)
      c = STORE_CYCLES;
    return c;
  endfunction

  function automatic logic [2:0] oeps_bytes(input oeps_instr_type ins);
    logic [2:0] b;
    b = 3'(SETPTR_BYTES);
    if (ins.op == OEPS_OP_OR)
      b = ins.use_imm ? 3'(OR_IMM_BYTES) : 3'(OR_REG_BYTES);
    else if (ins.op == OEPS_OP_STORE)
      b = 3'(STORE_BYTES);
    return b;
  endfunction
endpackage

// *** src/oeps_cycle_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module oeps_cycle_timer
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [16:0] count_i,
  output logic busy_o,
  output logic last_o
);
  logic [16:0] left_q;
  logic [16:0] left_d;

  always_comb
  begin
    left_d = left_q;
    if (load_i)
      left_d = count_i;
    else if (left_q != 17'h00000)
      left_d = left_q - 17'h00001;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      left_q <= 17'h00000;
    else
      left_q <= left_d;
  end

  assign busy_o = (left_q > 17'h00001);
  assign last_o = (left_q == 17'h00001);
endmodule // oeps_cycle_timer
`default_nettype wire

// *** src/oeps_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: OR writes destination accumulator with itself ORed with accumulator or 24-bit constant.
// RQ2: OR is 2 bytes register form, 5 bytes with constant.
// RQ3: OR takes 3 cycles register form, 6 cycles with constant.
// RQ4: Store copies chosen accumulator to EEPROM word addressed by the pointer.
// RQ5: Store reaches only EEPROM bytes 2000 to 2047 via pointer values 0 to 15.
// RQ6: Store takes 65536 cycles, about 50 ms.
// RQ7: Store occupies one program counter stack slot while running; slot must be free.
// RQ8: Programs should not put store behind a skip instruction.
// RQ9: Set-pointer loads pointer from 5-bit operand; one byte, one cycle.
// RQ10: Fetch holds until the EEPROM write ends; accumulators and pointer keep values.
// RQ11: OR updates only sign and zero flags; carry and overflow stay.
module oeps_exec
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic issue_i,
  input wire oeps_pkg::oeps_instr_type instr_i,
  input wire logic stack_free_i,
  output logic ready_o,
  output logic done_o,
  output logic [2:0] instr_bytes_o,
  output logic stack_hold_o,
  output logic stack_error_o,
  output logic range_error_o,
  output oeps_pkg::oeps_ee_write_type ee_write_o,
  output logic [95:0] work_accumulator_o,
  output oeps_pkg::oeps_flags_type sign_zero_flags_o,
  output logic [4:0] ram_pointer_o
);
  typedef enum logic [1:0] {
    OEPS_IDLE = 2'b01,
    OEPS_BUSY = 2'b10
  } oeps_state_type;

  oeps_state_type state_q, state_d;
  oeps_pkg::oeps_instr_type cur_q, cur_d;
  logic [23:0] acc_q [4];
  logic [23:0] acc_d [4];
  oeps_pkg::oeps_flags_type flags_q, flags_d;
  logic [4:0] ptr_q, ptr_d;
  logic done_q, done_d;
  logic [2:0] bytes_q, bytes_d;
  logic hold_q, hold_d;
  logic serr_q, serr_d;
  logic rerr_q, rerr_d;
  oeps_pkg::oeps_ee_write_type ee_q, ee_d;
  logic timer_load;
  logic [16:0] timer_count;
  logic timer_busy;
  logic timer_last;
  logic [23:0] or_src;
  logic [23:0] or_res;
  logic accept;

  oeps_cycle_timer u_timer
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .busy_o(timer_busy),
    .last_o(timer_last)
  );

  assign accept = issue_i && (state_q == OEPS_IDLE);
  assign or_src = cur_q.use_imm ? cur_q.imm : acc_q[cur_q.src]; // RQ1
  assign or_res = acc_q[cur_q.dst] | or_src; // RQ1

  always_comb
  begin
    state_d = state_q;
    cur_d = cur_q;
    acc_d = acc_q;
    flags_d = flags_q;
    ptr_d = ptr_q;
    done_d = 1'b0;
    bytes_d = bytes_q;
    hold_d = hold_q;
    serr_d = 1'b0;
    rerr_d = 1'b0;
    ee_d = ee_q;
    ee_d.valid = 1'b0;
    timer_load = 1'b0;
    // The accept cycle is the first cycle of the instruction, so the timer is loaded one short.
    timer_count = oeps_pkg::oeps_cycles(instr_i) - 17'h00001; // RQ3 RQ6
    unique case (state_q)
      OEPS_IDLE:
      begin
        if (accept)
        begin
          bytes_d = oeps_pkg::oeps_bytes(instr_i); // RQ2
          if (instr_i.op == oeps_pkg::OEPS_OP_SETPTR)
          begin
            ptr_d = instr_i.ptr; // RQ9
            done_d = 1'b1;
          end
          else if (instr_i.op == oeps_pkg::OEPS_OP_STORE && !stack_free_i)
          begin
            serr_d = 1'b1; // RQ7
            done_d = 1'b1;
          end
          else if (instr_i.op == oeps_pkg::OEPS_OP_STORE && ptr_q > oeps_pkg::PTR_LAST_EE)
          begin
            rerr_d = 1'b1; // RQ5
            done_d = 1'b1;
          end
          else if (instr_i.op != oeps_pkg::OEPS_OP_NONE)
          begin
            cur_d = instr_i;
            timer_load = 1'b1;
            state_d = OEPS_BUSY;
            if (instr_i.op == oeps_pkg::OEPS_OP_STORE)
            begin
              hold_d = 1'b1; // RQ7
              ee_d.valid = 1'b1; // RQ4
              ee_d.data = acc_q[instr_i.src]; // RQ4
              ee_d.addr = oeps_pkg::EE_WINDOW_BASE + {6'h00, ptr_q}; // RQ5
            end
          end
          else
          begin
            done_d = 1'b1;
          end
        end
      end
      OEPS_BUSY:
      begin
        if (timer_last)
        begin
          state_d = OEPS_IDLE;
          done_d = 1'b1;
          hold_d = 1'b0;
          if (cur_q.op == oeps_pkg::OEPS_OP_OR)
          begin
            acc_d[cur_q.dst] = or_res; // RQ1
            flags_d.sign = or_res[23]; // RQ11
            flags_d.zero = (or_res == 24'h000000); // RQ11
          end
        end
      end
      default:
      begin
        state_d = OEPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= OEPS_IDLE;
      cur_q <= '0;
      for (int i = 0; i < 4; i++)
        acc_q[i] <= oeps_pkg::ACC_RESET;
      flags_q <= '0;
      ptr_q <= oeps_pkg::PTR_RESET;
      done_q <= 1'b0;
      bytes_q <= 3'h0;
      hold_q <= 1'b0;
      serr_q <= 1'b0;
      rerr_q <= 1'b0;
      ee_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cur_q <= cur_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      ptr_q <= ptr_d;
      done_q <= done_d;
      bytes_q <= bytes_d;
      hold_q <= hold_d;
      serr_q <= serr_d;
      rerr_q <= rerr_d;
      ee_q <= ee_d;
    end
  end

  // Ready falls on the same edge on which an OR or store enters the busy state, so fetch stalls during a store.
  logic ready_q;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      ready_q <= 1'b1;
    else
      ready_q <= (state_d == OEPS_IDLE); // RQ10
  end

  assign ready_o = ready_q;
  assign done_o = done_q;
  assign instr_bytes_o = bytes_q;
  assign stack_hold_o = hold_q;
  assign stack_error_o = serr_q;
  assign range_error_o = rerr_q;
  assign ee_write_o = ee_q;
  assign work_accumulator_o = {acc_q[3], acc_q[2], acc_q[1], acc_q[0]};
  assign sign_zero_flags_o = flags_q;
  assign ram_pointer_o = ptr_q;

  logic [16:0] busy_cnt_q;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || accept)
      busy_cnt_q <= 17'h00000;
    else if (state_q == OEPS_BUSY)
      busy_cnt_q <= busy_cnt_q + 17'h00001;
  end

  AST_OR_REG_TIME: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
    accept && instr_i.op == oeps_pkg::OEPS_OP_OR && !instr_i.use_imm |=> !done_q [*2] ##1 done_q)
    else $error("OR register form not done after 3 cycles.");
  AST_OR_IMM_TIME: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
    accept && instr_i.op == oeps_pkg::OEPS_OP_OR && instr_i.use_imm |=> !done_q [*5] ##1 done_q)
    else $error("OR constant form not done after 6 cycles.");
  AST_OR_RESULT: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ1
    state_q == OEPS_BUSY && timer_last && cur_q.op == oeps_pkg::OEPS_OP_OR
    |=> work_accumulator_o[24*cur_q.dst +: 24] == $past(or_res))
    else $error("OR result not written.");
  AST_OR_FLAGS: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ11
    done_q |-> sign_zero_flags_o.carry == $past(sign_zero_flags_o.carry)
    && sign_zero_flags_o.overflow == $past(sign_zero_flags_o.overflow))
    else $error("Carry or overflow changed.");
  AST_OR_BYTES: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ2
    accept && instr_i.op == oeps_pkg::OEPS_OP_OR |=> instr_bytes_o == ($past(instr_i.use_imm) ? 3'h5 : 3'h2))
    else $error("OR byte count wrong.");
  AST_STORE_ADDR: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ5
    ee_write_o.valid |-> ee_write_o.addr >= 11'h7D0 && ee_write_o.addr <= 11'h7FF)
    else $error("EEPROM address out of window.");
  AST_STORE_DATA: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ4
    accept && instr_i.op == oeps_pkg::OEPS_OP_STORE && stack_free_i && ram_pointer_o <= 5'h0F
    |=> ee_write_o.valid && ee_write_o.data == work_accumulator_o[24*cur_q.src +: 24])
    else $error("Store data mismatch.");
  AST_STORE_TIME: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ6
    done_q && $past(state_q) == OEPS_BUSY && $past(cur_q.op) == oeps_pkg::OEPS_OP_STORE
    |-> busy_cnt_q == oeps_pkg::STORE_CYCLES - 17'h00001)
    else $error("Store did not last 65536 cycles.");
  AST_TIMER_RUN: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
    state_q == OEPS_BUSY |-> timer_busy || timer_last)
    else $error("Cycle timer idle while an instruction executes.");
  AST_STORE_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ10
    state_q == OEPS_BUSY |-> !ready_o && $stable(ram_pointer_o))
    else $error("Fetch or pointer moved during execution.");
  AST_STACK: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ7
    accept && instr_i.op == oeps_pkg::OEPS_OP_STORE && !stack_free_i |=> stack_error_o && !stack_hold_o)
    else $error("Store without free stack slot not refused.");
  AST_SETPTR: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ9
    accept && instr_i.op == oeps_pkg::OEPS_OP_SETPTR |=> done_q && ram_pointer_o == $past(instr_i.ptr))
    else $error("Pointer not loaded in one cycle.");
  COV_OR_IMM: cover property (@(posedge clock_i) accept && instr_i.op == oeps_pkg::OEPS_OP_OR && instr_i.use_imm);
  COV_STORE: cover property (@(posedge clock_i) ee_write_o.valid);
  COV_SETPTR: cover property (@(posedge clock_i) accept && instr_i.op == oeps_pkg::OEPS_OP_SETPTR);
endmodule // oeps_exec
`default_nettype wire

// *** dv/or_eeprom_store_ptr_ops_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module or_eeprom_store_ptr_ops_test;
  typedef struct packed {
    oeps_pkg::oeps_instr_type ins;
    logic [16:0] cyc;
    logic [2:0] bytes;
  } oeps_row_type;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic issue_i = 1'b0;
  logic stack_free_i = 1'b1;
  oeps_pkg::oeps_instr_type instr_i;
  logic ready_o;
  logic done_o;
  logic [2:0] instr_bytes_o;
  logic stack_hold_o;
  logic stack_error_o;
  logic range_error_o;
  oeps_pkg::oeps_ee_write_type ee_write_o;
  logic [95:0] work_accumulator_o;
  oeps_pkg::oeps_flags_type sign_zero_flags_o;
  logic [4:0] ram_pointer_o;
  logic [23:0] exp_acc [4];
  oeps_pkg::oeps_flags_type exp_flg;
  logic [4:0] exp_ptr;
  oeps_row_type rows [8];
  int failures = 0;
  int num_checks = 0;

  oeps_exec dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .instr_i(instr_i),
    .stack_free_i(stack_free_i), .ready_o(ready_o), .done_o(done_o), .instr_bytes_o(instr_bytes_o),
    .stack_hold_o(stack_hold_o), .stack_error_o(stack_error_o), .range_error_o(range_error_o),
    .ee_write_o(ee_write_o), .work_accumulator_o(work_accumulator_o),
    .sign_zero_flags_o(sign_zero_flags_o), .ram_pointer_o(ram_pointer_o));

  always #5 clock_i = ~clock_i;

  task automatic print_verdict;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  function automatic oeps_pkg::oeps_instr_type mk(input oeps_pkg::oeps_op_type op, input logic [1:0] d,
    input logic [1:0] s, input logic u, input logic [23:0] imm, input logic [4:0] p);
    return '{op: op, dst: d, src: s, use_imm: u, imm: imm, ptr: p};
  endfunction

  task automatic apply(input oeps_pkg::oeps_instr_type ins);
    logic [23:0] r;
    if (ins.op == oeps_pkg::OEPS_OP_SETPTR)
      exp_ptr = ins.ptr;
    if (ins.op == oeps_pkg::OEPS_OP_OR)
    begin
      r = exp_acc[ins.dst] | (ins.use_imm ? ins.imm : exp_acc[ins.src]);
      exp_acc[ins.dst] = r;
      exp_flg.sign = r[23];
      exp_flg.zero = (r == 24'h000000);
    end
  endtask

  // Issues one instruction (with poke, also a set-pointer while it is busy), follows it to done and compares all results with the model.
  task automatic do_op(input oeps_pkg::oeps_instr_type ins, input logic [16:0] cyc, input logic [2:0] bytes,
    input logic [1:0] err, input logic poke);
    int n;
    logic st;
    n = 0;
    st = (ins.op == oeps_pkg::OEPS_OP_STORE) && (err == 2'b00);
    @(negedge clock_i);
    instr_i = ins;
    issue_i = 1'b1;
    do
    begin
      @(negedge clock_i);
      n++;
      if (n == 1)
        issue_i = 1'b0;
      if (poke && n == 2)
      begin
        issue_i = 1'b1;
        instr_i = mk(oeps_pkg::OEPS_OP_SETPTR, 2'h0, 2'h0, 1'b0, 24'h000000, 5'h05);
      end
      if (poke && n == 3)
        issue_i = 1'b0;
      if (n == 1)
        check(ee_write_o.valid === st, "ee write strobe");
      if (n == 1 && st)
        check(ee_write_o === {1'b1, 11'(11'h7D0 + 11'(exp_ptr)), exp_acc[ins.src]}, "ee word");
      if (done_o !== 1'b1)
        check(ready_o === 1'b0 && stack_hold_o === st, "busy state");
    end
    while (done_o !== 1'b1 && n < 70000);
    if (n >= 70000)
    begin
      failures++;
      $display("unexpected at %0t: no done", $time);
      print_verdict();
    end
    check(n == int'(cyc), "cycle count");
    check({stack_error_o, range_error_o} === err && ready_o === 1'b1, "end state");
    check(stack_hold_o === 1'b0, "stack slot kept");
    if (err == 2'b00)
    begin
      apply(ins);
      check(instr_bytes_o === bytes, "byte length");
    end
    check(work_accumulator_o === {exp_acc[3], exp_acc[2], exp_acc[1], exp_acc[0]}, "accumulators");
    check(sign_zero_flags_o === exp_flg, "flags");
    check(ram_pointer_o === exp_ptr, "pointer");
  endtask

  initial
  begin
    instr_i = mk(oeps_pkg::OEPS_OP_NONE, 2'h0, 2'h0, 1'b0, 24'h000000, 5'h00);
    exp_acc = '{24'h000000, 24'h000000, 24'h000000, 24'h000000};
    exp_flg = '0;
    exp_ptr = 5'h00;
    rows[0] = '{mk(oeps_pkg::OEPS_OP_SETPTR, 2'h0, 2'h0, 1'b0, 24'h000000, 5'h1F), 17'h00001, 3'h1};
    rows[1] = '{mk(oeps_pkg::OEPS_OP_OR, 2'h0, 2'h0, 1'b1, 24'h800001, 5'h00), 17'h00006, 3'h5};
    rows[2] = '{mk(oeps_pkg::OEPS_OP_OR, 2'h1, 2'h0, 1'b1, 24'h00F0F0, 5'h00), 17'h00006, 3'h5};
    rows[3] = '{mk(oeps_pkg::OEPS_OP_OR, 2'h2, 2'h1, 1'b0, 24'hFFFFFF, 5'h00), 17'h00003, 3'h2};
    rows[4] = '{mk(oeps_pkg::OEPS_OP_OR, 2'h2, 2'h0, 1'b0, 24'h000000, 5'h00), 17'h00003, 3'h2};
    rows[5] = '{mk(oeps_pkg::OEPS_OP_OR, 2'h3, 2'h3, 1'b0, 24'h000000, 5'h00), 17'h00003, 3'h2};
    rows[6] = '{mk(oeps_pkg::OEPS_OP_OR, 2'h3, 2'h0, 1'b1, 24'h000000, 5'h00), 17'h00006, 3'h5};
    rows[7] = '{mk(oeps_pkg::OEPS_OP_SETPTR, 2'h0, 2'h0, 1'b0, 24'h000000, 5'h0F), 17'h00001, 3'h1};
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    check(ready_o === 1'b1 && done_o === 1'b0 && work_accumulator_o === 96'h0, "reset state");
    check(ram_pointer_o === 5'h00 && sign_zero_flags_o === 4'h0, "reset flags");
    foreach (rows[i])
      do_op(rows[i].ins, rows[i].cyc, rows[i].bytes, 2'b00, 1'b0);
    do_op(mk(oeps_pkg::OEPS_OP_STORE, 2'h0, 2'h2, 1'b0, 24'h000000, 5'h00), 17'h10000, 3'h4, 2'b00, 1'b1);
    stack_free_i = 1'b0;
    do_op(mk(oeps_pkg::OEPS_OP_STORE, 2'h0, 2'h0, 1'b0, 24'h000000, 5'h00), 17'h00001, 3'h4, 2'b10, 1'b0);
    stack_free_i = 1'b1;
    do_op(mk(oeps_pkg::OEPS_OP_SETPTR, 2'h0, 2'h0, 1'b0, 24'h000000, 5'h10), 17'h00001, 3'h1, 2'b00, 1'b0);
    do_op(mk(oeps_pkg::OEPS_OP_STORE, 2'h0, 2'h1, 1'b0, 24'h000000, 5'h00), 17'h00001, 3'h4, 2'b01, 1'b0);
    do_op(mk(oeps_pkg::OEPS_OP_NONE, 2'h0, 2'h0, 1'b0, 24'h000000, 5'h00), 17'h00001, 3'h1, 2'b00, 1'b0);
    // A reset in the middle of an OR with a constant drops it and restores the reset state.
    @(negedge clock_i);
    instr_i = mk(oeps_pkg::OEPS_OP_OR, 2'h1, 2'h0, 1'b1, 24'h0F0000, 5'h00);
    issue_i = 1'b1;
    @(negedge clock_i);
    issue_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    check(ready_o === 1'b1 && done_o === 1'b0 && work_accumulator_o === 96'h0, "mid reset state");
    check(ram_pointer_o === 5'h00 && sign_zero_flags_o === 4'h0 && ee_write_o === '0, "mid reset flags");
    exp_acc = '{24'h000000, 24'h000000, 24'h000000, 24'h000000};
    exp_flg = '0;
    exp_ptr = 5'h00;
    do_op(mk(oeps_pkg::OEPS_OP_OR, 2'h1, 2'h0, 1'b1, 24'h0F0000, 5'h00), 17'h00006, 3'h5, 2'b00, 1'b0);
    print_verdict();
  end
endmodule // or_eeprom_store_ptr_ops_test
`default_nettype wire
